// >>> verilog/chg_regs.vh
// Constants for the charger control block: register map, fields, reset values, timing.
// Assumes a 25 MHz clk_i and a classic Wishbone slave with 32-bit data.
`ifndef CHG_REGS_VH
`define CHG_REGS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CHG_ADR_CTRL      4'h0
`define CHG_ADR_CURR      4'h4
`define CHG_ADR_IRQ       4'h8
`define CHG_ADR_STATUS    4'hc

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CHG_CTRL_NTC      0
`define CHG_CTRL_STYLE    1
`define CHG_CTRL_SUSP     2
`define CHG_CTRL_VHOT     3
`define CHG_CTRL_VCOLD    4
`define CHG_CTRL_IHOT     5
`define CHG_CTRL_ICOLD    6
`define CHG_CTRL_MASK     7
`define CHG_CTRL_RST      8'h83
`define CHG_CURR_RST      4'h4
`define CHG_CURR_MAX      4'hb

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define CHG_ST_INPUT_POWER_GOOD      0
`define CHG_ST_ZONE       1
`define CHG_ST_DONE       4
`define CHG_ST_THR        5
`define CHG_ST_SAFE       6
`define CHG_ST_BATTERY_ABSENT_FLAG      7
`define CHG_ST_RUN        8
`define CHG_ST_DPM        9
`define CHG_ST_MODE       10

// ----------------------------------------
// Charge modes
// ----------------------------------------
`define CHG_M_IDLE        3'h0
`define CHG_M_PRE         3'h1
`define CHG_M_FAST        3'h2
`define CHG_M_CV          3'h3
`define CHG_M_DONE        3'h4
`define CHG_M_FAULT       3'h5
`define CHG_M_SUSP        3'h6

// ----------------------------------------
// Timing (clock 25 MHz)
// ----------------------------------------
`define CHG_CLK_KHZ       25000
`define CHG_TERM_MS       25
`define CHG_RECHG_MS      100
`define CHG_WAKE_DG_MS    40
`define CHG_WAKE_PW_MS    70
`define CHG_TERM_CYC      (`CHG_TERM_MS * `CHG_CLK_KHZ)
`define CHG_RECHG_CYC     (`CHG_RECHG_MS * `CHG_CLK_KHZ)
`define CHG_WAKE_DG_CYC   (`CHG_WAKE_DG_MS * `CHG_CLK_KHZ)
`define CHG_WAKE_PW_CYC   (`CHG_WAKE_PW_MS * `CHG_CLK_KHZ)
`define CHG_FLASH4_CYC    (`CHG_CLK_KHZ * 125)
`define CHG_FLASH05_CYC   (`CHG_CLK_KHZ * 1000)
`define CHG_FAULT_CYC     (`CHG_CLK_KHZ * 1000 * 60)

`endif

// >>> verilog/chg_sync.v
// Two-flop synchroniser, one per bit.
// Assumes inputs come from outside the clk_i domain.
`default_nettype none
module chg_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else if (ce_i) begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule
`default_nettype wire

// >>> verilog/chg_dgl.v
// Deglitch counter: output rises once the condition has held for N cycles.
// Assumes the condition is already synchronous to clk_i.
`default_nettype none
module chg_dgl #(
  parameter N = 16,
  parameter W = 32
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  input  wire cond_i,
  output wire done_o
);
  reg [W-1:0] cnt_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= {W{1'b0}};
    end else if (ce_i) begin
      if (!cond_i) begin
        cnt_r <= {W{1'b0}};
      end else if (cnt_r != N[W-1:0]) begin
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
  assign done_o = (cnt_r == N[W-1:0]);
endmodule
`default_nettype wire

// >>> verilog/chg_top.v
// Charger control, status and interrupt logic with a Wishbone register slave.
// Assumes comparator outputs arrive asynchronously; the bus is on clk_i.
`include "chg_regs.vh"
`default_nettype none
module chg_top #(
  parameter TERM_CYC    = `CHG_TERM_CYC,
  parameter RECHG_CYC   = `CHG_RECHG_CYC,
  parameter WAKE_DG_CYC = `CHG_WAKE_DG_CYC,
  parameter WAKE_PW_CYC = `CHG_WAKE_PW_CYC,
  parameter FLASH4_CYC  = `CHG_FLASH4_CYC,
  parameter FLASH05_CYC = `CHG_FLASH05_CYC,
  parameter FAULT_CYC   = `CHG_FAULT_CYC
) (
  // Clock, reset, enable
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Analog comparator inputs
  input  wire        pu_enable_i,
  input  wire        vbat_below_pre_i,
  input  wire        vbat_above_fast_i,
  input  wire        vbat_near_cv_i,
  input  wire        vbat_below_rechg_i,
  input  wire        ichg_below_term_i,
  input  wire        vin_above_uvlo_i,
  input  wire        vin_above_bat_os_i,
  input  wire        vin_above_ovp_i,
  input  wire        thermistor_above_absent_i,
  input  wire [2:0]  thermistor_zone_code_i,
  input  wire        die_thermal_reg_i,
  input  wire        dpm_active_i,
  input  wire        bat_plug_i,
  // Charger controls
  output reg         charge_enable_o,
  output reg         precharge_o,
  output reg         fault_current_o,
  output reg  [3:0]  fast_charge_current_code_o,
  output reg         cv_adjust_o,
  output reg         current_adjust_o,
  output reg         ntc_range_select_o,
  // Pins
  output reg         charge_indicator_pin_o,
  output reg         charge_indicator_pin_oe_o,
  output reg         irq_pin_o,
  output reg         irq_pin_oe_o,
  output reg         wake_pulse_o
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire [15:0] raw;
  wire [15:0] syn;
  assign raw = {bat_plug_i, dpm_active_i, die_thermal_reg_i, thermistor_zone_code_i,
                thermistor_above_absent_i, vin_above_ovp_i, vin_above_bat_os_i,
                vin_above_uvlo_i, ichg_below_term_i, vbat_below_rechg_i,
                vbat_near_cv_i, vbat_above_fast_i, vbat_below_pre_i, pu_enable_i};
  chg_sync #(.W(16)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (raw),
    .q_o   (syn)
  );
  wire       en_s     = syn[0];
  wire       pre_s    = syn[1];
  wire       fast_s   = syn[2];
  wire       cv_s     = syn[3];
  wire       rechg_s  = syn[4];
  wire       term_s   = syn[5];
  wire       uvlo_s   = syn[6];
  wire       os_s     = syn[7];
  wire       ovp_s    = syn[8];
  wire       absent_s = syn[9];
  wire [2:0] zone_s   = syn[12:10];
  wire       thr_s    = syn[13];
  wire       dpm_s    = syn[14];
  wire       plug_s   = syn[15];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0] ctrl_r;
  reg  [3:0] curr_r;
  reg        irq_r;
  reg  [2:0] mode_r;
  reg  [2:0] mode_nxt;
  reg        safe_r;
  reg  [9:0] flags_q_r;
  reg        pu_seen_r;
  reg        en_q_r;
  reg        susp_q_r;
  reg        ovp_q_r;
  reg        absent_q_r;
  reg        vin_q_r;
  reg        rechg_r;

  wire susp      = ctrl_r[`CHG_CTRL_SUSP];
  wire zone_ok   = (zone_s != 3'h0);
  wire input_power_good     = uvlo_s & os_s & ~ovp_s;
  wire battery_absent_flag     = en_s & absent_s;
  wire done_flag = (mode_r == `CHG_M_DONE) | rechg_r;
  wire run_flag  = (mode_r == `CHG_M_PRE) | (mode_r == `CHG_M_FAST) | (mode_r == `CHG_M_CV);

  // ----------------------------------------
  // Deglitch timers
  // ----------------------------------------
  wire term_done;
  wire rechg_done;
  chg_dgl #(.N(TERM_CYC)) u_term (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .cond_i ((mode_r == `CHG_M_CV) & cv_s & term_s),
    .done_o (term_done)
  );
  chg_dgl #(.N(RECHG_CYC)) u_rechg (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .cond_i ((mode_r == `CHG_M_DONE) & rechg_s),
    .done_o (rechg_done)
  );

  // ----------------------------------------
  // Fault release and safety timer
  // ----------------------------------------
  wire release_evt = (en_s ^ en_q_r) | (susp ^ susp_q_r) | (ovp_s & ~ovp_q_r)
                   | (absent_s & ~absent_q_r) | (input_power_good & ~vin_q_r);
  reg [31:0] safe_cnt_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      safe_cnt_r <= 32'h0;
    end else if (ce_i) begin
      if (release_evt || mode_r == `CHG_M_IDLE || mode_r == `CHG_M_DONE) begin
        safe_cnt_r <= 32'h0;
      end else if (mode_r == `CHG_M_FAST && zone_ok && safe_cnt_r != FAULT_CYC[31:0]) begin
        safe_cnt_r <= safe_cnt_r + 32'h1;
      end
    end
  end
  wire fault_hit = (safe_cnt_r == FAULT_CYC[31:0]);

  // ----------------------------------------
  // Charge mode machine
  // ----------------------------------------
  always @* begin
    mode_nxt = mode_r;
    case (mode_r)
      `CHG_M_IDLE:  if (input_power_good && !absent_s) mode_nxt = pre_s ? `CHG_M_PRE : `CHG_M_FAST;
      `CHG_M_PRE:   if (fast_s) mode_nxt = `CHG_M_FAST;
      `CHG_M_FAST:  begin
        if (fault_hit) mode_nxt = `CHG_M_FAULT;
        else if (pre_s) mode_nxt = `CHG_M_PRE;
        else if (cv_s) mode_nxt = `CHG_M_CV;
      end
      `CHG_M_CV:    if (term_done) mode_nxt = `CHG_M_DONE;
      `CHG_M_DONE:  if (rechg_done) mode_nxt = `CHG_M_FAST;
      `CHG_M_FAULT: if (release_evt) mode_nxt = `CHG_M_IDLE;
      `CHG_M_SUSP:  if (!susp) mode_nxt = `CHG_M_IDLE;
      default:      mode_nxt = `CHG_M_IDLE;
    endcase
    if (susp) mode_nxt = `CHG_M_SUSP;
    else if ((!input_power_good || absent_s) && mode_r != `CHG_M_FAULT) mode_nxt = `CHG_M_IDLE;
  end

  // ----------------------------------------
  // Indicator flash timebases
  // ----------------------------------------
  reg [31:0] f4_cnt_r;
  reg [31:0] f05_cnt_r;
  reg        f4_r;
  reg        f05_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      f4_cnt_r  <= 32'h0;
      f05_cnt_r <= 32'h0;
      f4_r      <= 1'b0;
      f05_r     <= 1'b0;
    end else if (ce_i) begin
      if (f4_cnt_r == FLASH4_CYC[31:0] - 32'h1) begin
        f4_cnt_r <= 32'h0;
        f4_r     <= ~f4_r;
      end else begin
        f4_cnt_r <= f4_cnt_r + 32'h1;
      end
      if (f05_cnt_r == FLASH05_CYC[31:0] - 32'h1) begin
        f05_cnt_r <= 32'h0;
        f05_r     <= ~f05_r;
      end else begin
        f05_cnt_r <= f05_cnt_r + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Wake pulse
  // ----------------------------------------
  wire       wake_dg;
  reg        wake_dg_q_r;
  reg [31:0] wake_cnt_r;
  wire       vin_above_ok = uvlo_s;
  chg_dgl #(.N(WAKE_DG_CYC)) u_wake (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .cond_i (plug_s | vin_above_ok),
    .done_o (wake_dg)
  );
  always @(posedge clk_i) begin
    if (rst_i) begin
      wake_dg_q_r  <= 1'b0;
      wake_cnt_r   <= 32'h0;
      wake_pulse_o <= 1'b0;
    end else if (ce_i) begin
      wake_dg_q_r <= wake_dg;
      if (wake_cnt_r != 32'h0) begin
        wake_cnt_r   <= wake_cnt_r - 32'h1;
        wake_pulse_o <= (wake_cnt_r != 32'h1);
      end else if (wake_dg && !wake_dg_q_r && !en_s) begin
        wake_cnt_r   <= WAKE_PW_CYC[31:0];
        wake_pulse_o <= 1'b1;
      end else begin
        wake_pulse_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupt events
  // ----------------------------------------
  wire [9:0] flags = {dpm_s, run_flag, battery_absent_flag, safe_r, thr_s, done_flag, zone_s, input_power_good};
  wire [9:0] chg   = flags ^ flags_q_r;
  wire       evt_run  = flags_q_r[8] & ~run_flag;
  wire       evt_dpm  = chg[9] & ~ctrl_r[`CHG_CTRL_MASK];
  wire       evt_on   = ~pu_seen_r & en_s & (input_power_good | battery_absent_flag | ~zone_ok | done_flag | thr_s | safe_r
                      | (dpm_s & ~ctrl_r[`CHG_CTRL_MASK]));
  wire       evt_any  = (pu_seen_r & ((|chg[7:0]) | evt_run | evt_dpm)) | evt_on;
  wire       wr       = cyc_i & stb_i & we_i & ~ack_o;
  wire       irq_wr0  = wr && adr_i == `CHG_ADR_IRQ && sel_i[0] && !dat_i[0];

  always @(posedge clk_i) begin
    if (rst_i) begin
      flags_q_r  <= 10'h0;
      pu_seen_r  <= 1'b0;
      irq_r      <= 1'b0;
      en_q_r     <= 1'b0;
      susp_q_r   <= 1'b0;
      ovp_q_r    <= 1'b0;
      absent_q_r <= 1'b0;
      vin_q_r    <= 1'b0;
      safe_r     <= 1'b0;
      mode_r     <= `CHG_M_IDLE;
      rechg_r    <= 1'b0;
    end else if (ce_i) begin
      flags_q_r  <= flags;
      pu_seen_r  <= en_s;
      en_q_r     <= en_s;
      susp_q_r   <= susp;
      ovp_q_r    <= ovp_s;
      absent_q_r <= absent_s;
      vin_q_r    <= input_power_good;
      safe_r     <= (mode_nxt == `CHG_M_FAULT);
      mode_r     <= mode_nxt;
      // Done stays up through a recharge after termination
      if (mode_r == `CHG_M_DONE && mode_nxt == `CHG_M_FAST) begin
        rechg_r <= 1'b1;
      end else if (mode_nxt != `CHG_M_FAST && mode_nxt != `CHG_M_CV) begin
        rechg_r <= 1'b0;
      end
      if (evt_any) irq_r <= 1'b1;
      else if (irq_wr0 || (en_s && !pu_seen_r)) irq_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `CHG_CTRL_RST;
      curr_r <= `CHG_CURR_RST;
      ack_o  <= 1'b0;
      dat_o  <= 32'h0;
    end else if (ce_i) begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= 32'h0;
      if (wr && adr_i == `CHG_ADR_CTRL && sel_i[0]) ctrl_r <= dat_i[7:0];
      if (wr && adr_i == `CHG_ADR_CURR && sel_i[0]) curr_r <= dat_i[3:0];
      if (cyc_i && stb_i && !we_i && !ack_o) begin
        case (adr_i)
          `CHG_ADR_CTRL:   dat_o <= {24'h0, ctrl_r};
          `CHG_ADR_CURR:   dat_o <= {28'h0, curr_r};
          `CHG_ADR_IRQ:    dat_o <= {31'h0, irq_r};
          `CHG_ADR_STATUS: dat_o <= {19'h0, mode_r, flags};
          default:         dat_o <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  wire hot  = (zone_s == 3'h5);
  wire cold = (zone_s == 3'h2);
  always @(posedge clk_i) begin
    if (rst_i) begin
      charge_enable_o            <= 1'b0;
      precharge_o                <= 1'b0;
      fault_current_o            <= 1'b0;
      fast_charge_current_code_o <= `CHG_CURR_RST;
      cv_adjust_o                <= 1'b0;
      current_adjust_o           <= 1'b0;
      ntc_range_select_o         <= 1'b1;
      charge_indicator_pin_o     <= 1'b0;
      charge_indicator_pin_oe_o  <= 1'b0;
      irq_pin_o                  <= 1'b0;
      irq_pin_oe_o               <= 1'b0;
    end else if (ce_i) begin
      charge_enable_o    <= run_flag & zone_ok;
      precharge_o        <= (mode_r == `CHG_M_PRE);
      fault_current_o    <= (mode_r == `CHG_M_FAULT);
      fast_charge_current_code_o <= (curr_r > `CHG_CURR_MAX) ? `CHG_CURR_MAX : curr_r;
      cv_adjust_o        <= (hot & ~ctrl_r[`CHG_CTRL_VHOT]) | (cold & ~ctrl_r[`CHG_CTRL_VCOLD]);
      current_adjust_o   <= (hot & ~ctrl_r[`CHG_CTRL_IHOT]) | (cold & ~ctrl_r[`CHG_CTRL_ICOLD]);
      ntc_range_select_o <= ctrl_r[`CHG_CTRL_NTC];
      charge_indicator_pin_o <= 1'b0;
      if (mode_r == `CHG_M_FAULT) begin
        charge_indicator_pin_oe_o <= f4_r;
      end else if (run_flag && !zone_ok) begin
        charge_indicator_pin_oe_o <= f05_r;
      end else if (run_flag) begin
        charge_indicator_pin_oe_o <= ctrl_r[`CHG_CTRL_STYLE] ? f05_r : 1'b1;
      end else begin
        charge_indicator_pin_oe_o <= 1'b0;
      end
      irq_pin_o    <= 1'b0;
      irq_pin_oe_o <= irq_r;
    end
  end

endmodule
`default_nettype wire

// >>> sim/chg_top_assertions.sv
// Port-level checker for the charger control block.
// Assumes ce_i stays high and the bind at the foot of this file.
`default_nettype none
module chg_top_assertions #(
  parameter int WAKE_PW_CYC = 24
) (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Watched pins and levels
  input wire logic        pu_enable_i,
  input wire logic        vbat_above_fast_i,
  input wire logic        precharge_o,
  input wire logic [3:0]  fast_charge_current_code_o,
  input wire logic        ntc_range_select_o,
  input wire logic        charge_indicator_pin_o,
  input wire logic        charge_indicator_pin_oe_o,
  input wire logic        irq_pin_o,
  input wire logic        irq_pin_oe_o,
  input wire logic        wake_pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       wr_ok;
  logic       clr_now;
  logic [1:0] clr_q_r;
  logic [3:0] pu_q_r;
  logic [3:0] cur_exp_r;
  logic       ntc_exp_r;
  logic       susp_r;
  logic [7:0] wcnt_r;
  assign wr_ok   = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  assign clr_now = wr_ok && adr_i == 4'h8 && !dat_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_q_r   <= 2'h0;
      pu_q_r    <= 4'h0;
      cur_exp_r <= 4'h4;
      ntc_exp_r <= 1'b1;
      susp_r    <= 1'b0;
      wcnt_r    <= 8'h0;
    end else begin
      clr_q_r <= {clr_q_r[0], clr_now};
      pu_q_r  <= {pu_q_r[2:0], pu_enable_i};
      if (wr_ok && adr_i == 4'h4) begin
        cur_exp_r <= (dat_i[3:0] > 4'hb) ? 4'hb : dat_i[3:0];
      end
      if (wr_ok && adr_i == 4'h0) begin
        ntc_exp_r <= dat_i[0];
        susp_r    <= dat_i[2];
      end
      wcnt_r <= wake_pulse_o ? wcnt_r + 8'h1 : 8'h0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence curr_wr_s; wr_ok && adr_i == 4'h4; endsequence
  sequence ctrl_wr_s; wr_ok && adr_i == 4'h0; endsequence
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held two cycles");
  read_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  irq_hold_a: assert property (irq_pin_oe_o && !clr_now && clr_q_r == 2'h0 && pu_q_r == {4{pu_enable_i}}
    |=> irq_pin_oe_o) else $error("interrupt dropped without clear");
  irq_od_a: assert property (!irq_pin_o && !charge_indicator_pin_o) else $error("open drain drives high");
  curr_code_a: assert property (curr_wr_s |-> ##2 fast_charge_current_code_o == cur_exp_r)
    else $error("current code wrong");
  ntc_sel_a: assert property (ctrl_wr_s |-> ##2 ntc_range_select_o == ntc_exp_r) else $error("ntc select wrong");
  susp_float_a: assert property (susp_r && $past(susp_r, 6) |-> !charge_indicator_pin_oe_o)
    else $error("indicator driven in suspend");
  wake_width_a: assert property ($fell(wake_pulse_o) |-> wcnt_r == 8'(WAKE_PW_CYC))
    else $error("wake pulse width wrong");
  fast_mode_a: assert property (vbat_above_fast_i [*6] |-> !precharge_o) else $error("precharge above fast level");
endmodule
bind chg_top chg_top_assertions #(.WAKE_PW_CYC(WAKE_PW_CYC)) u_chg_top_assertions (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pu_enable_i(pu_enable_i), .vbat_above_fast_i(vbat_above_fast_i),
  .precharge_o(precharge_o), .fast_charge_current_code_o(fast_charge_current_code_o),
  .ntc_range_select_o(ntc_range_select_o), .charge_indicator_pin_o(charge_indicator_pin_o),
  .charge_indicator_pin_oe_o(charge_indicator_pin_oe_o), .irq_pin_o(irq_pin_o), .irq_pin_oe_o(irq_pin_oe_o),
  .wake_pulse_o(wake_pulse_o));
`default_nettype wire

// >>> sim/chg_afe_model.sv
// Behavioural analog front end: battery and input comparators.
// Assumes levels in millivolts, changed by the bench just after a clock edge.
`default_nettype none
module chg_afe_model #(
  parameter int UVLO_MV = 3300,
  parameter int OS_MV   = 100,
  parameter int OVP_MV  = 6000
) (
  // Analog levels
  input  var int    vbat_mv,
  input  var int    vin_mv,
  input  wire logic ichg_low,
  // Comparator outputs
  output logic      vbat_below_pre_o,
  output logic      vbat_above_fast_o,
  output logic      vbat_near_cv_o,
  output logic      vbat_below_rechg_o,
  output logic      ichg_below_term_o,
  output logic      vin_above_uvlo_o,
  output logic      vin_above_bat_os_o,
  output logic      vin_above_ovp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign vbat_below_pre_o   = vbat_mv < 2800;
  assign vbat_above_fast_o  = vbat_mv > 3000;
  assign vbat_near_cv_o     = vbat_mv >= 4150;
  assign vbat_below_rechg_o = vbat_mv < 4100;
  assign ichg_below_term_o  = ichg_low;
  assign vin_above_uvlo_o   = vin_mv > UVLO_MV;
  assign vin_above_bat_os_o = vin_mv > vbat_mv + OS_MV;
  assign vin_above_ovp_o    = vin_mv > OVP_MV;
endmodule
`default_nettype wire

// >>> sim/chg_top_bench.sv
// Self-checking bench for the charger control block.
// Assumes shortened timing parameters and the front-end model.
`default_nettype none
module chg_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WDG = 16;
  localparam int WPW = 24;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic [3:0]  adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic        pu_en = 0, ichg_low = 0, absent = 0, input_voltage_limit_flag = 0, plug = 0, thermal_regulation_flag = 0;
  logic [2:0]  zone = 3'h3;
  int          vbat_mv = 3500, vin_mv = 0, miscompares = 0, tests_run = 0, n;
  int          vins[7] = '{5000, 3000, 5000, 3550, 5000, 6500, 5000};
  logic [31:0] pgs[7] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0, 32'h1};
  logic        b_pre, b_fast, b_cv, b_rechg, i_term, v_uvlo, v_os, v_ovp;
  logic        chg_en, pre, ind_oe, irq_oe, wake, ntc, cv_adj, i_adj;
  logic [3:0]  code;
  chg_afe_model u_chg_afe_model (.vbat_mv(vbat_mv), .vin_mv(vin_mv), .ichg_low(ichg_low),
    .vbat_below_pre_o(b_pre), .vbat_above_fast_o(b_fast), .vbat_near_cv_o(b_cv), .vbat_below_rechg_o(b_rechg),
    .ichg_below_term_o(i_term), .vin_above_uvlo_o(v_uvlo), .vin_above_bat_os_o(v_os), .vin_above_ovp_o(v_ovp));
  chg_top #(.TERM_CYC(20), .RECHG_CYC(30), .WAKE_DG_CYC(WDG), .WAKE_PW_CYC(WPW), .FLASH4_CYC(8),
    .FLASH05_CYC(16), .FAULT_CYC(20000)) u_chg_top (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pu_enable_i(pu_en), .vbat_below_pre_i(b_pre),
    .vbat_above_fast_i(b_fast), .vbat_near_cv_i(b_cv), .vbat_below_rechg_i(b_rechg), .ichg_below_term_i(i_term),
    .vin_above_uvlo_i(v_uvlo), .vin_above_bat_os_i(v_os), .vin_above_ovp_i(v_ovp),
    .thermistor_above_absent_i(absent), .thermistor_zone_code_i(zone), .die_thermal_reg_i(thermal_regulation_flag),
    .dpm_active_i(input_voltage_limit_flag), .bat_plug_i(plug), .charge_enable_o(chg_en), .precharge_o(pre), .fault_current_o(),
    .fast_charge_current_code_o(code), .cv_adjust_o(cv_adj), .current_adjust_o(i_adj), .ntc_range_select_o(ntc),
    .charge_indicator_pin_o(), .charge_indicator_pin_oe_o(ind_oe), .irq_pin_o(), .irq_pin_oe_o(irq_oe),
    .wake_pulse_o(wake));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
    if (k >= 50) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic rd_cmp(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp32(q & m, e);
  endtask
  task automatic wait_st(input logic [31:0] m, input logic [31:0] e);
    int i;
    i = 0;
    do begin
      wb(1'b0, 4'hc, 32'h0);
      i++;
    end while ((q & m) !== e && i < 200);
    cmp32(q & m, e);
    if ((q & m) !== e) report_and_stop();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_cmp(4'h0, 32'hff, 32'h83);
    rd_cmp(4'h4, 32'hf, 32'h4);
    wb(1'b1, 4'h2, 32'hff);
    rd_cmp(4'h2, 32'hffffffff, 32'h0);
    rd_cmp(4'h0, 32'hff, 32'h83);
    cmp_bit(ntc, 1'b1);
    for (int v = 0; v < 16; v++) begin
      wb(1'b1, 4'h4, 32'(v));
      @(posedge clk_i);
      cmp32({28'h0, code}, (v > 11) ? 32'hb : 32'(v));
    end
    $display("registers and current code done");
    plug <= 1'b1;
    for (n = 0; n < WDG + 20 && wake !== 1'b1; n++) @(posedge clk_i);
    pu_en <= 1'b1;
    n = 1;
    do begin
      @(posedge clk_i);
      if (wake === 1'b1) n++;
    end while (wake === 1'b1 && n < 200);
    cmp32(32'(n), 32'(WPW));
    pu_en <= 1'b1;
    plug  <= 1'b0;
    repeat (5) @(posedge clk_i);
    plug <= 1'b1;
    n = 0;
    repeat (WDG + WPW + 10) begin
      @(posedge clk_i);
      if (wake !== 1'b0) n++;
    end
    cmp32(32'(n), 32'h0);
    $display("wake pulse done");
    foreach (vins[i]) begin
      vin_mv <= vins[i];
      wait_st(32'h1, pgs[i]);
    end
    $display("power good done");
    wb(1'b1, 4'h0, 32'h81);
    vbat_mv <= 2500;
    wait_st(32'h1c00, 32'h400);
    cmp_bit(pre, 1'b1);
    vbat_mv <= 3500;
    wait_st(32'h1c00, 32'h800);
    cmp_bit(pre, 1'b0);
    cmp_bit(ind_oe, 1'b1);
    wb(1'b1, 4'h0, 32'h83);
    n = 0;
    repeat (32) begin
      @(posedge clk_i);
      if (ind_oe === 1'b1) n++;
    end
    cmp32(32'(n), 32'h10);
    wb(1'b1, 4'h0, 32'h81);
    vbat_mv <= 4200;
    wait_st(32'h1c00, 32'hc00);
    wb(1'b1, 4'h8, 32'h0);
    rd_cmp(4'h8, 32'h1, 32'h0);
    ichg_low <= 1'b1;
    wait_st(32'h1c10, 32'h1010);
    cmp_bit(ind_oe, 1'b0);
    rd_cmp(4'h8, 32'h1, 32'h1);
    cmp_bit(irq_oe, 1'b1);
    wb(1'b1, 4'h8, 32'h0);
    rd_cmp(4'h8, 32'h1, 32'h0);
    cmp_bit(irq_oe, 1'b0);
    vbat_mv <= 4000;
    wait_st(32'h1c00, 32'h800);
    rd_cmp(4'hc, 32'h10, 32'h10);
    cmp_bit(chg_en, 1'b1);
    $display("charge cycle done");
    repeat (10) @(posedge clk_i);
    wb(1'b1, 4'h8, 32'h0);
    input_voltage_limit_flag <= 1'b1;
    wait_st(32'h200, 32'h200);
    rd_cmp(4'h8, 32'h1, 32'h0);
    wb(1'b1, 4'h0, 32'h01);
    input_voltage_limit_flag <= 1'b0;
    wait_st(32'h200, 32'h0);
    rd_cmp(4'h8, 32'h1, 32'h1);
    wb(1'b1, 4'h8, 32'h0);
    zone <= 3'h0;
    wait_st(32'he, 32'h0);
    rd_cmp(4'h8, 32'h1, 32'h1);
    zone <= 3'h5;
    wait_st(32'he, 32'ha);
    cmp_bit(cv_adj, 1'b1);
    cmp_bit(i_adj, 1'b1);
    wb(1'b1, 4'h0, 32'h29);
    cmp_bit(cv_adj, 1'b0);
    cmp_bit(i_adj, 1'b0);
    zone <= 3'h3;
    wait_st(32'he, 32'h6);
    wb(1'b1, 4'h8, 32'h0);
    thermal_regulation_flag <= 1'b1;
    wait_st(32'h20, 32'h20);
    rd_cmp(4'h8, 32'h1, 32'h1);
    wb(1'b1, 4'h8, 32'h0);
    $display("interrupt events done");
    wb(1'b1, 4'h0, 32'h04);
    wait_st(32'h1c00, 32'h1800);
    cmp_bit(ind_oe, 1'b0);
    cmp_bit(ntc, 1'b0);
    wb(1'b1, 4'h8, 32'h0);
    absent <= 1'b1;
    wait_st(32'h80, 32'h80);
    rd_cmp(4'h8, 32'h1, 32'h1);
    $display("suspend and battery absent done");
    report_and_stop();
  end
endmodule
`default_nettype wire
